//--- include/sria_defs.svh
// Constants for the switch register indirect access bridge
`ifndef SRIA_DEFS_SVH
`define SRIA_DEFS_SVH
// Overview of operation
// [R01] Fabric registers reached only via data, command, window
// [R02] Host loads data register before single write
// [R03] Single write: one command with pending set
// [R04] Burst write: arm command, each data write starts
// [R05] Device steps address after each burst write completes
// [R06] Host writes next data after previous completes
// [R07] Window write sets address, lanes, direction, pending
// [R08] Window locations map to a fixed register subset
// [R09] Single read: one command with direction set
// [R10] Pending clears only once read data stored
// [R11] Burst read: arm command, pending clears per read
// [R12] Data read in burst steps address, starts read
// [R13] Host clears step bits before final burst read
// [R14] Host starts nothing new while pending is set

// ----------------------------------------------------------------
// Link offsets seen by the host end (byte addresses)
// ----------------------------------------------------------------
`define SRIA_LNK_DATA   8'h00
`define SRIA_LNK_CMD    8'h04
`define SRIA_WIN_BASE   8'h40
`define SRIA_WIN_SEL    3'h2

// ----------------------------------------------------------------
// Command register layout
// ----------------------------------------------------------------
`define SRIA_CMD_PEND   31
`define SRIA_CMD_DIR    30
`define SRIA_CMD_UP     29
`define SRIA_CMD_DN     28
`define SRIA_CMD_BE_HI  19
`define SRIA_CMD_BE_LO  16
`define SRIA_CMD_ADR_HI 15
`define SRIA_BE_ALL     4'hF
`define SRIA_DATA_RST   32'h00000000
`define SRIA_ADR_RST    16'h0000
`define SRIA_BE_RST     4'h0

// ----------------------------------------------------------------
// Window to fabric register map (eight word slots)
// ----------------------------------------------------------------
`define SRIA_WMAP_0     16'h0000
`define SRIA_WMAP_1     16'h0001
`define SRIA_WMAP_2     16'h0400
`define SRIA_WMAP_3     16'h0401
`define SRIA_WMAP_4     16'h0800
`define SRIA_WMAP_5     16'h0801
`define SRIA_WMAP_6     16'h1000
`define SRIA_WMAP_7     16'h1001

// ----------------------------------------------------------------
// Host controller registers (Avalon byte addresses)
// ----------------------------------------------------------------
`define SRIA_H_TGT      8'h00
`define SRIA_H_WDATA    8'h04
`define SRIA_H_RDATA    8'h08
`define SRIA_H_CTRL     8'h0C
`define SRIA_CTL_GO     0
`define SRIA_CTL_LAST   1
`define SRIA_STS_BUSY   0
`define SRIA_STS_ARMED  1

`endif

//--- include/sria_pkg.sv
// Types used by the host end of the indirect access bridge
package sria_pkg;
  typedef enum logic [2:0] {
    SRIA_S_IDLE  = 3'b000,
    SRIA_S_WDATA = 3'b001,
    SRIA_S_WCMD  = 3'b010,
    SRIA_S_POLL  = 3'b011,
    SRIA_S_CLRST = 3'b100,
    SRIA_S_RDATA = 3'b101,
    SRIA_S_WWIN  = 3'b110
  } sria_hstate_t;

  typedef enum logic [2:0] {
    SRIA_K_SWR = 3'b000,
    SRIA_K_SRD = 3'b001,
    SRIA_K_BWR = 3'b010,
    SRIA_K_BRD = 3'b011,
    SRIA_K_WIN = 3'b100
  } sria_kind_t;
endpackage : sria_pkg

//--- include/sria_link_if.sv
// Register link between the host controller and the bridge
`timescale 1ns/1ps
`default_nettype none
interface sria_link_if;
  logic        req;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;

  modport dev (
    input  req,
    input  wr,
    input  addr,
    input  wdata,
    output rdata,
    output ack
  );

  modport host (
    output req,
    output wr,
    output addr,
    output wdata,
    input  rdata,
    input  ack
  );
endinterface : sria_link_if
`default_nettype wire

//--- hw/sria_device.sv
// Bridge end: data and command registers, window and fabric port
`timescale 1ns/1ps
`default_nettype none
`include "sria_defs.svh"
module sria_device (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_IN,
  // Host link
  sria_link_if.dev         lnk,
  // Fabric register port
  output var  logic        FAB_REQ_OUT,
  output var  logic        FAB_WR_OUT,
  output var  logic [15:0] FAB_ADDR_OUT,
  output var  logic [3:0]  FAB_BE_OUT,
  output var  logic [31:0] FAB_WDATA_OUT,
  input  wire logic [31:0] FAB_RDATA_IN,
  input  wire logic        FAB_ACK_IN
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] data_q;
  logic        pend_q;
  logic        dir_q;
  logic        up_q;
  logic        dn_q;
  logic [3:0]  be_q;
  logic [15:0] adr_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        req_q;
  logic        fwr_q;
  logic [15:0] fadr_q;
  logic [3:0]  fbe_q;
  logic [31:0] fwd_q;

  // ----------------------------------------------------------------
  // Link decode
  // ----------------------------------------------------------------
  logic        take;
  logic        is_data;
  logic        is_cmd;
  logic        is_win;
  logic [2:0]  win_idx;
  logic [15:0] win_adr;
  logic        step_on;
  logic [15:0] step_adr;
  logic        cmd_ld;
  logic        start_cmd;
  logic        start_dwr;
  logic        start_win;
  logic        start_rd;
  logic        start;
  logic        done;
  logic [31:0] cmd_view;

  // A request is taken once; the host drops req after seeing ack
  assign take    = lnk.req && !ack_q;
  assign is_data = (lnk.addr == `SRIA_LNK_DATA);
  assign is_cmd  = (lnk.addr == `SRIA_LNK_CMD);
  assign is_win  = (lnk.addr[7:5] == `SRIA_WIN_SEL) && (lnk.addr[1:0] == 2'h0); // R01
  assign win_idx = lnk.addr[4:2];
  assign step_on = up_q || dn_q;
  // Increment wins if software sets both step bits
  assign step_adr = up_q ? 16'(adr_q + 16'h0001) : 16'(adr_q - 16'h0001);

  // Fixed window map; only a subset of fabric registers is reachable
  always_comb begin
    case (win_idx) // R08
      3'h0:    win_adr = `SRIA_WMAP_0;
      3'h1:    win_adr = `SRIA_WMAP_1;
      3'h2:    win_adr = `SRIA_WMAP_2;
      3'h3:    win_adr = `SRIA_WMAP_3;
      3'h4:    win_adr = `SRIA_WMAP_4;
      3'h5:    win_adr = `SRIA_WMAP_5;
      3'h6:    win_adr = `SRIA_WMAP_6;
      default: win_adr = `SRIA_WMAP_7;
    endcase
  end

  // Writes while an access is pending are dropped, so a stray write
  // cannot corrupt the access in flight
  assign cmd_ld    = take && lnk.wr && is_cmd && !pend_q;
  assign start_cmd = cmd_ld && lnk.wdata[`SRIA_CMD_PEND]; // R03 R09
  assign start_dwr = take && lnk.wr && is_data && !pend_q && !dir_q && step_on; // R04
  assign start_win = take && lnk.wr && is_win && !pend_q; // R07
  assign start_rd  = take && !lnk.wr && is_data && !pend_q && dir_q && step_on; // R12
  assign start     = start_cmd || start_dwr || start_win || start_rd;
  assign done      = req_q && FAB_ACK_IN;

  assign cmd_view = {pend_q, dir_q, up_q, dn_q, 8'h00, be_q, adr_q};

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pend_q <= 1'b0;
      dir_q  <= 1'b0;
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      be_q   <= `SRIA_BE_RST;
      adr_q  <= `SRIA_ADR_RST;
    end else if (cmd_ld) begin
      pend_q <= lnk.wdata[`SRIA_CMD_PEND]; // R03 R09
      dir_q  <= lnk.wdata[`SRIA_CMD_DIR];
      up_q   <= lnk.wdata[`SRIA_CMD_UP]; // R04 R11
      dn_q   <= lnk.wdata[`SRIA_CMD_DN];
      be_q   <= lnk.wdata[`SRIA_CMD_BE_HI:`SRIA_CMD_BE_LO];
      adr_q  <= lnk.wdata[`SRIA_CMD_ADR_HI:0];
    end else if (start_win) begin
      adr_q  <= win_adr; // R07
      be_q   <= `SRIA_BE_ALL;
      dir_q  <= 1'b0;
      pend_q <= 1'b1;
    end else if (start_dwr) begin
      pend_q <= 1'b1; // R04
    end else if (start_rd) begin
      adr_q  <= step_adr; // R12
      pend_q <= 1'b1;
    end else if (done) begin
      pend_q <= 1'b0; // R03 R10 R11
      if (!dir_q && step_on) begin
        adr_q <= step_adr; // R05
      end
    end
  end

  // ----------------------------------------------------------------
  // Data register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      data_q <= `SRIA_DATA_RST;
    end else if (take && lnk.wr && (is_data || is_win) && !pend_q) begin
      data_q <= lnk.wdata; // R02
    end else if (done && dir_q) begin
      // Read data lands on the same edge that pending drops
      data_q <= FAB_RDATA_IN; // R10
    end
  end

  // ----------------------------------------------------------------
  // Link answer, one cycle after the request is taken
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ack_q   <= 1'b0;
      rdata_q <= `SRIA_DATA_RST;
    end else begin
      ack_q <= take;
      if (take && !lnk.wr) begin
        if (is_data) begin
          rdata_q <= data_q;
        end else if (is_cmd) begin
          rdata_q <= cmd_view;
        end else begin
          rdata_q <= `SRIA_DATA_RST;
        end
      end
    end
  end

  assign lnk.ack   = ack_q;
  assign lnk.rdata = rdata_q;

  // ----------------------------------------------------------------
  // Fabric port: request held until the fabric acknowledges
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      req_q  <= 1'b0;
      fwr_q  <= 1'b0;
      fadr_q <= `SRIA_ADR_RST;
      fbe_q  <= `SRIA_BE_RST;
      fwd_q  <= `SRIA_DATA_RST;
    end else if (start) begin
      req_q <= 1'b1;
      if (start_cmd) begin
        fwr_q  <= !lnk.wdata[`SRIA_CMD_DIR];
        fadr_q <= lnk.wdata[`SRIA_CMD_ADR_HI:0];
        fbe_q  <= lnk.wdata[`SRIA_CMD_BE_HI:`SRIA_CMD_BE_LO];
        fwd_q  <= data_q; // R02
      end else if (start_win) begin
        fwr_q  <= 1'b1; // R07
        fadr_q <= win_adr; // R08
        fbe_q  <= `SRIA_BE_ALL;
        fwd_q  <= lnk.wdata;
      end else if (start_dwr) begin
        fwr_q  <= 1'b1;
        fadr_q <= adr_q;
        fbe_q  <= be_q;
        fwd_q  <= lnk.wdata; // R04
      end else begin
        fwr_q  <= 1'b0;
        fadr_q <= step_adr; // R12
        fbe_q  <= be_q;
      end
    end else if (done) begin
      req_q <= 1'b0;
    end
  end

  assign FAB_REQ_OUT   = req_q;
  assign FAB_WR_OUT    = fwr_q;
  assign FAB_ADDR_OUT  = fadr_q;
  assign FAB_BE_OUT    = fbe_q;
  assign FAB_WDATA_OUT = fwd_q;

endmodule : sria_device
`default_nettype wire

//--- hw/sria_host.sv
// Host end: Avalon-MM controller that drives the bridge link
`timescale 1ns/1ps
`default_nettype none
`include "sria_defs.svh"
module sria_host (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_IN,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  output var  logic [31:0] AVS_READDATA_OUT,
  output var  logic        AVS_WAITREQUEST_OUT,
  // Bridge link
  sria_link_if.host        lnk
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sria_pkg::sria_hstate_t st_q;
  sria_pkg::sria_kind_t   kind_q;
  sria_pkg::sria_kind_t   kind_d;
  logic [31:0] tgt_q;
  logic [31:0] wd_q;
  logic [31:0] rd_q;
  logic [31:0] win_d_q;
  logic [7:0]  win_a_q;
  logic        armed_q;
  logic        last_q;
  logic        wait_q;
  logic [31:0] avrd_q;
  logic        lreq_q;
  logic        lwr_q;
  logic [7:0]  ladr_q;
  logic [31:0] lwd_q;
  logic        acc;
  logic        go;
  logic        win_go;
  logic        step;
  logic        lwr_d;
  logic [7:0]  ladr_d;
  logic [31:0] lwd_d;
  sria_pkg::sria_hstate_t nxt;
  sria_pkg::sria_hstate_t go_st;

  // Control writes stall while busy; reads are always answered
  assign acc    = (AVS_READ_IN || AVS_WRITE_IN) && wait_q &&
                  (AVS_READ_IN || st_q == sria_pkg::SRIA_S_IDLE); // R14
  assign go     = acc && AVS_WRITE_IN && AVS_ADDRESS_IN == `SRIA_H_CTRL &&
                  AVS_WRITEDATA_IN[`SRIA_CTL_GO];
  assign win_go = acc && AVS_WRITE_IN && AVS_ADDRESS_IN[7:5] == `SRIA_WIN_SEL;
  assign step   = tgt_q[`SRIA_CMD_UP] || tgt_q[`SRIA_CMD_DN];

  always_comb begin
    kind_d = tgt_q[`SRIA_CMD_DIR] ? (step ? sria_pkg::SRIA_K_BRD : sria_pkg::SRIA_K_SRD)
                                  : (step ? sria_pkg::SRIA_K_BWR : sria_pkg::SRIA_K_SWR);
    case (kind_d)
      sria_pkg::SRIA_K_SWR: go_st = sria_pkg::SRIA_S_WDATA; // R02
      sria_pkg::SRIA_K_BWR: go_st = armed_q ? sria_pkg::SRIA_S_WDATA : sria_pkg::SRIA_S_WCMD;
      sria_pkg::SRIA_K_BRD: go_st = armed_q ? sria_pkg::SRIA_S_POLL : sria_pkg::SRIA_S_WCMD;
      default:              go_st = sria_pkg::SRIA_S_WCMD;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer: one link access per state, advanced on ack
  // ----------------------------------------------------------------
  always_comb begin
    nxt = sria_pkg::SRIA_S_IDLE;
    case (st_q)
      sria_pkg::SRIA_S_WDATA: nxt = (kind_q == sria_pkg::SRIA_K_SWR) ? sria_pkg::SRIA_S_WCMD
                                                                  : sria_pkg::SRIA_S_POLL;
      sria_pkg::SRIA_S_WCMD:  nxt = (kind_q == sria_pkg::SRIA_K_BWR) ? sria_pkg::SRIA_S_WDATA
                                                                  : sria_pkg::SRIA_S_POLL;
      sria_pkg::SRIA_S_POLL: begin
        if (lnk.rdata[`SRIA_CMD_PEND]) begin
          nxt = sria_pkg::SRIA_S_POLL; // R06 R14
        end else if (kind_q == sria_pkg::SRIA_K_SRD) begin
          nxt = sria_pkg::SRIA_S_RDATA;
        end else if (kind_q == sria_pkg::SRIA_K_BRD) begin
          nxt = last_q ? sria_pkg::SRIA_S_CLRST : sria_pkg::SRIA_S_RDATA; // R13
        end
      end
      sria_pkg::SRIA_S_CLRST: nxt = sria_pkg::SRIA_S_RDATA;
      sria_pkg::SRIA_S_WWIN:  nxt = sria_pkg::SRIA_S_POLL;
      default:                nxt = sria_pkg::SRIA_S_IDLE;
    endcase
  end

  // Link fields for the access of the current state
  always_comb begin
    lwr_d  = 1'b1;
    ladr_d = `SRIA_LNK_CMD;
    lwd_d  = tgt_q;
    case (st_q)
      sria_pkg::SRIA_S_WDATA: begin
        ladr_d = `SRIA_LNK_DATA;
        lwd_d  = wd_q;
      end
      sria_pkg::SRIA_S_WCMD: lwd_d[`SRIA_CMD_PEND] = (kind_q != sria_pkg::SRIA_K_BWR); // R03 R04 R09 R11
      sria_pkg::SRIA_S_POLL: lwr_d = 1'b0;
      sria_pkg::SRIA_S_CLRST: begin
        lwd_d[`SRIA_CMD_PEND] = 1'b0;
        lwd_d[`SRIA_CMD_UP]   = 1'b0; // R13
        lwd_d[`SRIA_CMD_DN]   = 1'b0;
      end
      sria_pkg::SRIA_S_RDATA: begin
        lwr_d  = 1'b0;
        ladr_d = `SRIA_LNK_DATA;
      end
      sria_pkg::SRIA_S_WWIN: begin
        ladr_d = win_a_q;
        lwd_d  = win_d_q;
      end
      default: lwr_d = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_q   <= sria_pkg::SRIA_S_IDLE;
      kind_q <= sria_pkg::SRIA_K_SWR;
      lreq_q <= 1'b0;
      lwr_q  <= 1'b0;
      ladr_q <= `SRIA_LNK_DATA;
      lwd_q  <= `SRIA_DATA_RST;
      rd_q   <= `SRIA_DATA_RST;
    end else if (go) begin
      st_q   <= go_st;
      kind_q <= kind_d;
    end else if (win_go) begin
      st_q   <= sria_pkg::SRIA_S_WWIN;
      kind_q <= sria_pkg::SRIA_K_WIN;
    end else if (lreq_q && lnk.ack) begin
      lreq_q <= 1'b0;
      st_q   <= nxt;
      if (st_q == sria_pkg::SRIA_S_RDATA) begin
        rd_q <= lnk.rdata;
      end
    end else if (!lreq_q && !lnk.ack && st_q != sria_pkg::SRIA_S_IDLE) begin
      lreq_q <= 1'b1;
      lwr_q  <= lwr_d;
      ladr_q <= ladr_d;
      lwd_q  <= lwd_d;
    end
  end

  // ----------------------------------------------------------------
  // Software registers and Avalon answer
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      tgt_q   <= `SRIA_DATA_RST;
      wd_q    <= `SRIA_DATA_RST;
      win_d_q <= `SRIA_DATA_RST;
      win_a_q <= `SRIA_WIN_BASE;
      armed_q <= 1'b0;
      last_q  <= 1'b0;
    end else if (acc && AVS_WRITE_IN) begin
      case (AVS_ADDRESS_IN)
        `SRIA_H_TGT: begin
          tgt_q   <= AVS_WRITEDATA_IN;
          armed_q <= 1'b0;
        end
        `SRIA_H_WDATA: wd_q <= AVS_WRITEDATA_IN;
        `SRIA_H_CTRL: begin
          last_q  <= AVS_WRITEDATA_IN[`SRIA_CTL_LAST];
          if (go) begin
            armed_q <= step && !(tgt_q[`SRIA_CMD_DIR] && AVS_WRITEDATA_IN[`SRIA_CTL_LAST]);
          end
        end
        default: begin
          if (win_go) begin
            win_a_q <= AVS_ADDRESS_IN;
            win_d_q <= AVS_WRITEDATA_IN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wait_q <= 1'b1;
      avrd_q <= `SRIA_DATA_RST;
    end else begin
      wait_q <= !acc;
      if (acc && AVS_READ_IN) begin
        case (AVS_ADDRESS_IN)
          `SRIA_H_TGT:   avrd_q <= tgt_q;
          `SRIA_H_WDATA: avrd_q <= wd_q;
          `SRIA_H_RDATA: avrd_q <= rd_q;
          `SRIA_H_CTRL:  avrd_q <= {30'h00000000, armed_q, st_q != sria_pkg::SRIA_S_IDLE};
          default:       avrd_q <= `SRIA_DATA_RST;
        endcase
      end
    end
  end

  assign AVS_WAITREQUEST_OUT = wait_q;
  assign AVS_READDATA_OUT    = avrd_q;
  assign lnk.req             = lreq_q;
  assign lnk.wr              = lwr_q;
  assign lnk.addr            = ladr_q;
  assign lnk.wdata           = lwd_q;

endmodule : sria_host
`default_nettype wire

//--- tb/sria_link_asserts.sv
// Assertions on the link and fabric port of the indirect access bridge
`timescale 1ns/1ps
`default_nettype none
`include "sria_defs.svh"
module sria_link_asserts (
  // Clock and reset
  input wire logic        SYS_CLK_IN,
  input wire logic        RESET_IN,
  // Link
  input wire logic        req,
  input wire logic        wr,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  // Fabric port
  input wire logic        FAB_REQ_OUT,
  input wire logic        FAB_WR_OUT,
  input wire logic [15:0] FAB_ADDR_OUT,
  input wire logic [3:0]  FAB_BE_OUT,
  input wire logic        FAB_ACK_IN
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic take;
  logic poll_busy_q;
  assign take = req && !ack;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A status read taken while the fabric is busy must report pending
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      poll_busy_q <= 1'b0;
    end else begin
      poll_busy_q <= take && !wr && addr == `SRIA_LNK_CMD && FAB_REQ_OUT && !FAB_ACK_IN;
    end
  end
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("link ack wider than one cycle");
  ack_timing_a: assert property (take |=> ack)
    else $error("link ack late");
  link_hold_a: assert property (take |=> req && $stable(wr) && $stable(addr) && $stable(wdata))
    else $error("link request changed before ack");
  req_release_a: assert property (ack |=> !req)
    else $error("link request held after ack");
  fab_start_a: assert property ($rose(FAB_REQ_OUT) |-> ack && $past(take))
    else $error("fabric access without link request");
  cmd_launch_a: assert property (take && wr && addr == `SRIA_LNK_CMD && wdata[31] |=> FAB_REQ_OUT
    && FAB_WR_OUT == !wdata[30] && FAB_ADDR_OUT == wdata[15:0] && (!FAB_WR_OUT || FAB_BE_OUT == wdata[19:16]))
    else $error("command did not launch its access");
  win_launch_a: assert property (take && wr && addr >= `SRIA_WIN_BASE |=> FAB_REQ_OUT && FAB_WR_OUT
    && FAB_BE_OUT == `SRIA_BE_ALL) else $error("window write launch wrong");
  fab_hold_a: assert property (FAB_REQ_OUT && !FAB_ACK_IN |=> FAB_REQ_OUT && $stable(FAB_ADDR_OUT)
    && $stable(FAB_WR_OUT) && $stable(FAB_BE_OUT)) else $error("fabric request changed early");
  fab_release_a: assert property (FAB_REQ_OUT && FAB_ACK_IN |=> !FAB_REQ_OUT)
    else $error("fabric request held after ack");
  pend_shown_a: assert property (ack && poll_busy_q |-> rdata[`SRIA_CMD_PEND])
    else $error("pending clear before completion");
  cover property (take && wr && addr >= `SRIA_WIN_BASE);
  cover property (FAB_REQ_OUT && FAB_ACK_IN && !FAB_WR_OUT);
  cover property (ack && poll_busy_q);
endmodule : sria_link_asserts
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the indirect access bridge
`timescale 1ns/1ps
`default_nettype none
`include "sria_defs.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  av_addr = 8'h00;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wd = 32'h00000000;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        f_req;
  logic        f_wr;
  logic [15:0] f_addr;
  logic [3:0]  f_be;
  logic [31:0] f_wd;
  logic        f_ack = 1'b0;
  logic [31:0] f_rd = 32'h00000000;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] mdl [int];
  logic [31:0] fmem [int];
  logic [52:0] exp_q [$];
  logic [52:0] e;
  logic [31:0] r;
  logic [31:0] d;
  logic [15:0] a;
  logic [3:0]  be;
  logic [15:0] wmap [8] = '{`SRIA_WMAP_0, `SRIA_WMAP_1, `SRIA_WMAP_2, `SRIA_WMAP_3,
                            `SRIA_WMAP_4, `SRIA_WMAP_5, `SRIA_WMAP_6, `SRIA_WMAP_7};

  sria_link_if lnk ();
  sria_host u_sria_host (.SYS_CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(av_addr), .AVS_READ_IN(av_rd),
    .AVS_WRITE_IN(av_wr), .AVS_WRITEDATA_IN(av_wd), .AVS_READDATA_OUT(av_rdata),
    .AVS_WAITREQUEST_OUT(av_wait), .lnk(lnk));
  sria_device u_sria_device (.SYS_CLK_IN(clk), .RESET_IN(rst), .lnk(lnk), .FAB_REQ_OUT(f_req),
    .FAB_WR_OUT(f_wr), .FAB_ADDR_OUT(f_addr), .FAB_BE_OUT(f_be), .FAB_WDATA_OUT(f_wd),
    .FAB_RDATA_IN(f_rd), .FAB_ACK_IN(f_ack));
  sria_link_asserts u_sria_link_asserts (.SYS_CLK_IN(clk), .RESET_IN(rst), .req(lnk.req), .wr(lnk.wr),
    .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack), .FAB_REQ_OUT(f_req),
    .FAB_WR_OUT(f_wr), .FAB_ADDR_OUT(f_addr), .FAB_BE_OUT(f_be), .FAB_ACK_IN(f_ack));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] fdef(input logic [15:0] x);
    return {16'hC3C3, x};
  endfunction : fdef

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
    for (int i = 0; i < 4; i++) if (m[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction : merge

  function automatic logic [31:0] cmd(input logic dr, input logic up, input logic dn,
                                      input logic [3:0] m, input logic [15:0] x);
    return {1'b0, dr, up, dn, 8'h00, m, x};
  endfunction : cmd

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
    comparisons++;
    if (s !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, x, s);
    end
  endtask : chk

  task automatic end_of_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Stalled accesses are bounded by this cycle ceiling, not per wait
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic av(input logic w, input logic [7:0] x, input logic [31:0] v);
    @(posedge clk);
    av_addr <= x;
    av_wd <= v;
    av_wr <= w;
    av_rd <= !w;
    do @(posedge clk); while (av_wait !== 1'b0);
    r = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : av

  task automatic expect_acc(input logic w, input logic [15:0] x, input logic [3:0] m, input logic [31:0] v);
    exp_q.push_back({w, x, m, v});
    if (w) mdl[x] = merge(mdl.exists(x) ? mdl[x] : fdef(x), v, m);
  endtask : expect_acc

  task automatic go(input logic last);
    av(1'b1, `SRIA_H_CTRL, {30'h0, last, 1'b1});
    do av(1'b0, `SRIA_H_CTRL, 32'h0); while (r[`SRIA_STS_BUSY] !== 1'b0);
  endtask : go

  task automatic rd_chk(input logic [15:0] x);
    av(1'b0, `SRIA_H_RDATA, 32'h0);
    chk("rdata", r, mdl.exists(x) ? mdl[x] : fdef(x));
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Fabric responder: random latency, scrambled data outside acks
  // ----------------------------------------------------------------
  initial begin
    forever begin
      @(posedge clk);
      if (f_req === 1'b1) begin
        repeat ($urandom_range(3)) @(posedge clk);
        if (exp_q.size() == 0) chk("fab_extra", 1, 0);
        else begin
          e = exp_q.pop_front();
          chk("fab_acc", e[52] ? {f_wr, f_addr, f_be, f_wd} : {f_wr, f_addr, 36'h0},
              e[52] ? e : {e[52:36], 36'h0});
        end
        if (f_wr) fmem[f_addr] = merge(fmem.exists(f_addr) ? fmem[f_addr] : fdef(f_addr), f_wd, f_be);
        f_rd <= f_wr ? ~f_rd : (fmem.exists(f_addr) ? fmem[f_addr] : fdef(f_addr));
        f_ack <= 1'b1;
        @(posedge clk);
        f_ack <= 1'b0;
        f_rd <= $urandom;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hBD3E));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, `SRIA_H_CTRL, 32'h0);
    chk("ctrl_rst", r, 0);
    av(1'b1, 8'h30, $urandom);
    for (int i = 0; i < 4; i++) begin
      a = $urandom;
      be = $urandom_range(15, 1);
      d = $urandom;
      expect_acc(1'b1, a, be, d);
      av(1'b1, `SRIA_H_TGT, cmd(1'b0, 1'b0, 1'b0, be, a));
      av(1'b1, `SRIA_H_WDATA, d);
      go(1'b0);
      expect_acc(1'b0, a, 4'h0, 32'h0);
      av(1'b1, `SRIA_H_TGT, cmd(1'b1, 1'b0, 1'b0, `SRIA_BE_ALL, a));
      go(1'b0);
      rd_chk(a);
    end
    for (int s = 0; s < 2; s++) begin
      a = $urandom_range(16'hFFF0, 16);
      av(1'b1, `SRIA_H_TGT, cmd(1'b0, s == 0, s == 1, `SRIA_BE_ALL, a));
      for (int k = 0; k < 3; k++) begin
        d = $urandom;
        expect_acc(1'b1, 16'(s ? a - k : a + k), `SRIA_BE_ALL, d);
        av(1'b1, `SRIA_H_WDATA, d);
        go(1'b0);
        chk("armed_wr", r[`SRIA_STS_ARMED], 1'b1);
      end
      av(1'b1, `SRIA_H_TGT, cmd(1'b1, s == 0, s == 1, `SRIA_BE_ALL, a));
      for (int k = 0; k < 3; k++) expect_acc(1'b0, 16'(s ? a - k : a + k), 4'h0, 32'h0);
      for (int k = 0; k < 3; k++) begin
        go(k == 2);
        chk("armed_rd", r[`SRIA_STS_ARMED], k != 2);
        rd_chk(16'(s ? a - k : a + k));
      end
    end
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      expect_acc(1'b1, wmap[i], `SRIA_BE_ALL, d);
      av(1'b1, 8'(`SRIA_WIN_BASE + 4 * i), d);
      expect_acc(1'b0, wmap[i], 4'h0, 32'h0);
      av(1'b1, `SRIA_H_TGT, cmd(1'b1, 1'b0, 1'b0, `SRIA_BE_ALL, wmap[i]));
      go(1'b0);
      rd_chk(wmap[i]);
    end
    repeat (10) @(posedge clk);
    chk("fab_left", exp_q.size(), 0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
